// ### rtl/hbea_regs.vh
// Constants for the host bridge endian converter and rotating arbiter.
// Assumes one clock, synchronous active-high reset, 64-bit data lanes.
//
// Operation
// - After reset every PCI-side address window decoder is disabled until software enables it.
// - The arbiter rotates priority so the last granted master becomes lowest priority.
// - Six requesters rotate in order host bridge, secondary bridge, expansion master, ISA bridge, Ethernet, mezzanine slot.
// - In big-endian mode bytes are swapped in both directions to keep byte addresses unchanged.
// - In little-endian mode PCI-bound addresses are reverse-rearranged and memory-bound ones rearranged, with no byte swap.
// - Both modes keep byte-stream data in address order across the two domains.
// - Processor-side registers, memory, boot storage and system registers always look big-endian.
`ifndef HBEA_REGS_VH
`define HBEA_REGS_VH

`define HBEA_NUM_MASTERS 6
// Same count at the width of the wrap sum, so the subtraction stays sized
`define HBEA_NUM_MASTERS_W1 4'h6
`define HBEA_MASTER_W 3
`define HBEA_NUM_WIN 4
`define HBEA_ADDR_W 32
`define HBEA_DATA_W 64
`define HBEA_BE_W 8
// Lane index flip used by address rearrangement (8-byte lanes)
`define HBEA_LANE_FLIP 3'h7
`define HBEA_GRANT_NONE 6'h00
`define HBEA_LAST_RESET 3'h5
`define HBEA_WIN_EN_RESET 4'h0
`define HBEA_MODE_BIG 1'b1

`endif

// ### rtl/hbea_arbiter.v
// Rotating-priority arbiter for six local bus masters.
// Assumes requests are synchronous; bus_idle marks end of a transaction.
`timescale 1ns/1ps
`default_nettype none
`include "hbea_regs.vh"
module hbea_arbiter (
    input wire clk,
    input wire srst,
    input wire [`HBEA_NUM_MASTERS-1:0] req,
    input wire bus_idle,
    output reg [`HBEA_NUM_MASTERS-1:0] gnt_r
);
    reg [`HBEA_MASTER_W-1:0] last_r;
    reg [`HBEA_MASTER_W-1:0] pick;
    reg found;
    reg [`HBEA_MASTER_W-1:0] idx;
    integer k;

    function [`HBEA_MASTER_W-1:0] hbea_wrap;
        input [`HBEA_MASTER_W:0] v;
        reg [`HBEA_MASTER_W:0] t;
        begin
            t = v - `HBEA_NUM_MASTERS_W1;
            if (v >= `HBEA_NUM_MASTERS_W1) begin
                hbea_wrap = t[`HBEA_MASTER_W-1:0];
            end else begin
                hbea_wrap = v[`HBEA_MASTER_W-1:0];
            end
        end
    endfunction

    // Search starts just after the last winner
    always @* begin
        pick = {`HBEA_MASTER_W{1'b0}};
        found = 1'b0;
        idx = {`HBEA_MASTER_W{1'b0}};
        for (k = 1; k <= `HBEA_NUM_MASTERS; k = k + 1) begin
            idx = hbea_wrap({1'b0, last_r} + k[`HBEA_MASTER_W:0]);
            if (!found && req[idx]) begin
                found = 1'b1;
                pick = idx;
            end
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            gnt_r <= `HBEA_GRANT_NONE;
            last_r <= `HBEA_LAST_RESET;
        end else if (gnt_r == `HBEA_GRANT_NONE || bus_idle) begin
            // Grant moves only once the owner's transfer is over
            if (found) begin
                gnt_r <= {{(`HBEA_NUM_MASTERS-1){1'b0}}, 1'b1} << pick;
                last_r <= pick;
            end else begin
                gnt_r <= `HBEA_GRANT_NONE;
            end
        end
    end
endmodule // hbea_arbiter
`default_nettype wire

// ### rtl/hbea_bridge.v
// Host-to-PCI bridge datapath: endian conversion, window gating, arbiter.
// Assumes processor side is big-endian, PCI side little-endian, one clock.
`timescale 1ns/1ps
`default_nettype none
`include "hbea_regs.vh"
module hbea_bridge (
    input wire clk,
    input wire srst,
    input wire big_endian_mode,
    input wire win_en_wr,
    input wire [`HBEA_NUM_WIN-1:0] win_en_wdata,
    input wire cpu_valid,
    input wire [`HBEA_ADDR_W-1:0] cpu_addr,
    input wire [`HBEA_DATA_W-1:0] cpu_data,
    input wire [`HBEA_BE_W-1:0] cpu_be,
    input wire pci_valid,
    input wire [`HBEA_NUM_WIN-1:0] pci_win_hit,
    input wire [`HBEA_ADDR_W-1:0] pci_addr,
    input wire [`HBEA_DATA_W-1:0] pci_data,
    input wire [`HBEA_BE_W-1:0] pci_be,
    input wire [`HBEA_NUM_MASTERS-1:0] bus_req,
    input wire bus_idle,
    output reg [`HBEA_NUM_WIN-1:0] win_en_r,
    output reg pci_out_valid_r,
    output reg [`HBEA_ADDR_W-1:0] pci_out_addr_r,
    output reg [`HBEA_DATA_W-1:0] pci_out_data_r,
    output reg [`HBEA_BE_W-1:0] pci_out_be_r,
    output reg mem_out_valid_r,
    output reg [`HBEA_ADDR_W-1:0] mem_out_addr_r,
    output reg [`HBEA_DATA_W-1:0] mem_out_data_r,
    output reg [`HBEA_BE_W-1:0] mem_out_be_r,
    output wire [`HBEA_NUM_MASTERS-1:0] bus_gnt_r
);
    // Byte swap across an 8-byte lane keeps byte addresses invariant
    function [`HBEA_DATA_W-1:0] hbea_swap;
        input [`HBEA_DATA_W-1:0] d;
        integer i;
        begin
            for (i = 0; i < `HBEA_BE_W; i = i + 1) begin
                hbea_swap[i*8 +: 8] = d[(`HBEA_BE_W-1-i)*8 +: 8];
            end
        end
    endfunction

    function [`HBEA_BE_W-1:0] hbea_swap_be;
        input [`HBEA_BE_W-1:0] b;
        integer i;
        begin
            for (i = 0; i < `HBEA_BE_W; i = i + 1) begin
                hbea_swap_be[i] = b[`HBEA_BE_W-1-i];
            end
        end
    endfunction

    // Rearrangement is an XOR of the low lane bits; it is its own inverse,
    // so the same function serves both the rearrange and reverse forms.
    function [`HBEA_ADDR_W-1:0] hbea_rearr;
        input [`HBEA_ADDR_W-1:0] a;
        begin
            hbea_rearr = {a[`HBEA_ADDR_W-1:3], a[2:0] ^ `HBEA_LANE_FLIP};
        end
    endfunction

    wire pci_hit;
    assign pci_hit = |(pci_win_hit & win_en_r);

    always @(posedge clk) begin
        if (srst) begin
            win_en_r <= `HBEA_WIN_EN_RESET;
        end else if (win_en_wr) begin
            win_en_r <= win_en_wdata;
        end
    end

    // Processor to PCI
    always @(posedge clk) begin
        if (srst) begin
            pci_out_valid_r <= 1'b0;
            pci_out_addr_r <= {`HBEA_ADDR_W{1'b0}};
            pci_out_data_r <= {`HBEA_DATA_W{1'b0}};
            pci_out_be_r <= {`HBEA_BE_W{1'b0}};
        end else begin
            pci_out_valid_r <= cpu_valid;
            if (cpu_valid) begin
                if (big_endian_mode == `HBEA_MODE_BIG) begin
                    pci_out_addr_r <= cpu_addr;
                    pci_out_data_r <= hbea_swap(cpu_data);
                    pci_out_be_r <= hbea_swap_be(cpu_be);
                end else begin
                    pci_out_addr_r <= hbea_rearr(cpu_addr);
                    pci_out_data_r <= cpu_data;
                    pci_out_be_r <= cpu_be;
                end
            end
        end
    end

    // PCI to memory, only through an enabled window
    always @(posedge clk) begin
        if (srst) begin
            mem_out_valid_r <= 1'b0;
            mem_out_addr_r <= {`HBEA_ADDR_W{1'b0}};
            mem_out_data_r <= {`HBEA_DATA_W{1'b0}};
            mem_out_be_r <= {`HBEA_BE_W{1'b0}};
        end else begin
            mem_out_valid_r <= pci_valid && pci_hit;
            if (pci_valid && pci_hit) begin
                // Memory side stays big-endian in either mode
                if (big_endian_mode == `HBEA_MODE_BIG) begin
                    mem_out_addr_r <= pci_addr;
                    mem_out_data_r <= hbea_swap(pci_data);
                    mem_out_be_r <= hbea_swap_be(pci_be);
                end else begin
                    mem_out_addr_r <= hbea_rearr(pci_addr);
                    mem_out_data_r <= pci_data;
                    mem_out_be_r <= pci_be;
                end
            end
        end
    end

    hbea_arbiter u_arb (
        .clk(clk),
        .srst(srst),
        .req(bus_req),
        .bus_idle(bus_idle),
        .gnt_r(bus_gnt_r)
    );
endmodule // hbea_bridge
`default_nettype wire

// ### test/hbea_props.sv
// Checker for hbea_bridge ports: endian paths, window gate, arbiter.
// Bound from the bench; one clock, srst synchronous active high.
`timescale 1ns/1ps
`default_nettype none
module hbea_props (
    input wire logic clk, srst, big_endian_mode, cpu_valid, pci_valid,
    input wire logic bus_idle, pci_out_valid_r, mem_out_valid_r,
    input wire logic [31:0] cpu_addr, pci_addr, pci_out_addr_r, mem_out_addr_r,
    input wire logic [63:0] cpu_data, pci_data, pci_out_data_r, mem_out_data_r,
    input wire logic [7:0] cpu_be, pci_out_be_r,
    input wire logic [3:0] pci_win_hit, win_en_r,
    input wire logic [5:0] bus_req, bus_gnt_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire hit = pci_valid && |(pci_win_hit & win_en_r);
    wire [5:0] nxt = {bus_gnt_r[4:0], bus_gnt_r[5]};
    chk_win_reset: assert property ($fell(srst) |-> win_en_r == 4'h0)
        else $error("windows open after reset");
    chk_win_gate: assert property (pci_valid && !hit |=> !mem_out_valid_r)
        else $error("beat passed a closed window");
    chk_cpu_big: assert property (cpu_valid && big_endian_mode |=>
        pci_out_valid_r && pci_out_addr_r == $past(cpu_addr) &&
        pci_out_data_r == {<<8{$past(cpu_data)}} &&
        pci_out_be_r == {<<{$past(cpu_be)}}) else $error("cpu big beat");
    chk_cpu_little: assert property (cpu_valid && !big_endian_mode |=>
        pci_out_addr_r == ($past(cpu_addr) ^ 32'h7) &&
        pci_out_data_r == $past(cpu_data)) else $error("cpu little beat");
    chk_mem_big: assert property (hit && big_endian_mode |=>
        mem_out_valid_r && mem_out_data_r == {<<8{$past(pci_data)}})
        else $error("mem big beat");
    chk_mem_little: assert property (hit && !big_endian_mode |=>
        mem_out_addr_r == ($past(pci_addr) ^ 32'h7) &&
        mem_out_data_r == $past(pci_data)) else $error("mem little beat");
    chk_gnt_one: assert property ($onehot0(bus_gnt_r))
        else $error("several grants");
    chk_gnt_hold: assert property (bus_gnt_r != 6'h00 && !bus_idle |=>
        $stable(bus_gnt_r)) else $error("grant moved while busy");
    chk_rotate: assert property (bus_idle && |(bus_req & nxt) |=>
        bus_gnt_r == $past(nxt)) else $error("rotation skipped");
    cover property (hit && big_endian_mode);
    cover property (cpu_valid && !big_endian_mode);
    cover property (bus_gnt_r == 6'h20 && bus_idle);
endmodule // hbea_props
`default_nettype wire

// ### test/hbea_masters.sv
// Local masters: each holds its request until its transfer ends.
// Assumes grants come from the bridge; len sets transfer length.
`timescale 1ns/1ps
`default_nettype none
module hbea_masters (
    input wire logic clk,
    input wire logic srst,
    input wire logic [5:0] want,
    input wire logic [3:0] len,
    input wire logic [5:0] bus_gnt,
    output var logic [5:0] bus_req,
    output logic bus_idle
);
    logic [5:0] prev_r;
    logic [3:0] cnt_r;
    wire fresh = bus_gnt != 6'h00 && bus_gnt != prev_r;
    // Busy from the grant's own cycle, else the arbiter moves on at once
    assign bus_idle = cnt_r == 4'h0 && !fresh;
    always @(posedge clk) begin
        prev_r <= srst ? 6'h00 : bus_gnt;
        if (srst) cnt_r <= 4'h0;
        else if (fresh) cnt_r <= len;
        else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
        if (srst) bus_req <= 6'h00;
        else bus_req <= (bus_req | want) & ~(bus_idle ? bus_gnt : 6'h00);
    end
endmodule // hbea_masters
`default_nettype wire

// ### test/hbea_bridge_tb.sv
// Bench for hbea_bridge: endian table, window gate, arbiter, reset.
// Assumes hbea_masters as far side and hbea_props bound below.
`timescale 1ns/1ps
`default_nettype none
module hbea_bridge_tb;
    logic clk = 1'b0, srst = 1'b1, big_endian_mode = 1'b0, win_en_wr = 1'b0;
    logic cpu_valid = 1'b0, pci_valid = 1'b0, bus_idle;
    logic pci_out_valid_r, mem_out_valid_r;
    logic [3:0] win_en_wdata = 4'h2, pci_win_hit = 4'hF, win_en_r, len = 4'h2;
    logic [31:0] cpu_addr = 32'h0, pci_addr = 32'h0, pci_out_addr_r;
    logic [31:0] mem_out_addr_r;
    logic [63:0] cpu_data = 64'h0, pci_data = 64'h0, pci_out_data_r;
    logic [63:0] mem_out_data_r;
    logic [7:0] cpu_be = 8'h0, pci_be = 8'h0, pci_out_be_r, mem_out_be_r;
    logic [5:0] bus_req, bus_gnt_r, want = 6'h00, g;
    int mismatches = 0, n_checks = 0, cyc = 0, i, k;
    // Row: mode, addr, data, be, then expected addr, data, be
    logic [208:0] rows [0:1] = '{
        {1'b1, 32'h1004, 64'h0102030405060708, 8'h0F,
         32'h1004, 64'h0807060504030201, 8'hF0},
        {1'b0, 32'h1004, 64'h0102030405060708, 8'h0F,
         32'h1003, 64'h0102030405060708, 8'h0F}};
    hbea_bridge dut (.*);
    hbea_masters partner (.clk(clk), .srst(srst), .want(want), .len(len),
        .bus_gnt(bus_gnt_r), .bus_req(bus_req), .bus_idle(bus_idle));
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            report_and_stop;
        end
    end
    task chk(input string nm, input logic [111:0] e, input logic [111:0] s);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        pci_valid <= 1'b1;
        @(posedge clk);
        pci_valid <= 1'b0;
        win_en_wr <= 1'b1;
        #1 chk("windows", 0, win_en_r);
        chk("mem_valid", 0, mem_out_valid_r);
        @(posedge clk);
        win_en_wr <= 1'b0;
        $display("reset test done");
        for (i = 0; i < 2; i++) begin
            {big_endian_mode, cpu_addr, cpu_data, cpu_be} <= rows[i][208:104];
            {pci_addr, pci_data, pci_be} <= rows[i][207:104];
            cpu_valid <= 1'b1;
            pci_valid <= 1'b1;
            @(posedge clk);
            cpu_valid <= 1'b0;
            pci_valid <= 1'b0;
            #1 chk("pci_out", {1'b1, rows[i][103:0]}, {pci_out_valid_r,
                pci_out_addr_r, pci_out_data_r, pci_out_be_r});
            chk("mem_out", {1'b1, rows[i][103:0]}, {mem_out_valid_r,
                mem_out_addr_r, mem_out_data_r, mem_out_be_r});
            @(posedge clk);
        end
        $display("endian test done");
        want <= 6'h3F;
        @(posedge clk);
        want <= 6'h00;
        g = 6'h00;
        for (i = 0; i < 6; i++) begin
            k = 0;
            while ((bus_gnt_r === 6'h00 || bus_gnt_r === g) && k < 40) begin
                @(posedge clk);
                #1 k++;
            end
            g = bus_gnt_r;
            chk("grant", 6'h01 << i, g);
        end
        $display("arbiter test done");
        @(posedge clk);
        want <= 6'h3F;
        repeat (4) @(posedge clk);
        srst <= 1'b1;
        want <= 6'h00;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        want <= 6'h21;
        #1 chk("reset_out", 0, {win_en_r, bus_gnt_r});
        @(posedge clk);
        want <= 6'h00;
        @(posedge clk);
        #1 chk("first_grant", 6'h01, bus_gnt_r);
        $display("mid reset test done");
        report_and_stop;
    end
endmodule // hbea_bridge_tb
bind hbea_bridge hbea_props chk_i (.*);
`default_nettype wire
